// ### design/gsf_cfg.svh
// Constants for the register, segment and flag state block
// Summary of operation
// - Sixteen registers; default operand size 32 bits
// - Extension prefix enables 64-bit size, regs 8-15
// - Byte, word, dword, qword access in 64-bit mode with prefix
// - With prefix, high-byte codes select index lows
// - 64-bit writes all; 32-bit zero-extends
// - 8/16-bit writes keep upper bits
// - Upper eight kept through compatibility round trip
// - Upper halves may drop leaving 64-bit mode
// - Six 16-bit segment selectors
// - Code selector loads only implicitly
// - Fetch address from code selector plus offset
// - Stack uses stack selector; explicitly loadable
// - 64-bit: four bases zero, third/fourth usable
// - 64-bit: no limit checks on any segment
// - 64-bit selector loads still validity checked
// - Reset or init sets flags to 00000002
// - Flag bits 1,3,5,15,22-31 reserved
// - No whole-flags access; groups move only
// - Task switch saves then loads flags
// - Handler call pushes flags onto stack
// - Wide flags: upper 32 reserved
`ifndef GSF_CFG_SVH
`define GSF_CFG_SVH
`define GSF_NUM_GPR 16
`define GSF_FLAGS_RESET 32'h0000_0002
`define GSF_FLAGS_FIXED_MASK 32'hffc0_802a
`define GSF_FLAGS_WRITE_MASK 32'h003f_7fd5
`define GSF_LOW_GROUP_MASK 32'h0000_00d5
`define GSF_SEG_CODE 3'h0
`define GSF_SEG_STACK 3'h1
`define GSF_SEG_DATA 3'h2
`define GSF_SEG_EXTRA 3'h3
`define GSF_SEG_THIRD 3'h4
`define GSF_SEG_FOURTH 3'h5
`define GSF_SEL_RPL_LSB 2
`define GSF_HIGH_BYTE_ALIAS 4'h4
`endif

// ### design/gsf_pkg.sv
// Types shared by the register, segment and flag state block
package gsf_pkg;
  typedef enum logic [3:0] {
    GSF_SZ_BYTE = 4'h1,
    GSF_SZ_WORD = 4'h2,
    GSF_SZ_DWORD = 4'h4,
    GSF_SZ_QWORD = 4'h8
  } gsf_size_t;
  typedef enum logic [2:0] {
    GSF_MODE_LONG = 3'h1,
    GSF_MODE_COMPAT = 3'h2,
    GSF_MODE_LEGACY = 3'h4
  } gsf_mode_t;
  typedef enum logic [3:0] {
    GSF_FL_IDLE = 4'h1,
    GSF_FL_SAVE = 4'h2,
    GSF_FL_LOAD = 4'h4,
    GSF_FL_PUSH = 4'h8
  } gsf_flag_state_t;
endpackage : gsf_pkg

// ### design/gsf_regmem.sv
// Sixteen-entry general register storage with registered reads
`timescale 1ns/1ps
`default_nettype none
module gsf_regmem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 64
) (
  input wire logic clock,
  input wire logic [$clog2(DEPTH)-1:0] wr_index,
  input wire logic wr_enable,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_index,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_enable) begin
      mem_reg[wr_index] <= wr_data;
    end
  end

  // Write-through keeps a read after write in the same cycle coherent
  always_ff @(posedge clock) begin
    if (wr_enable && wr_index == rd_index) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem_reg[rd_index];
    end
  end
endmodule : gsf_regmem
`default_nettype wire

// ### design/gsf_state.sv
// Architectural register, segment selector and flag state
`timescale 1ns/1ps
`default_nettype none
`include "gsf_cfg.svh"
module gsf_state
  import gsf_pkg::*;
#(
  parameter int NUM_GPR = `GSF_NUM_GPR
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic init,
  input wire gsf_mode_t cpu_mode,
  // Register read/write port from the execute stage
  input wire logic gpr_req,
  input wire logic gpr_write,
  input wire logic [3:0] gpr_code,
  input wire logic gpr_prefix,
  input wire logic gpr_wide,
  input wire logic gpr_byte_op,
  input wire logic gpr_word_op,
  input wire logic [63:0] gpr_wdata,
  output logic [63:0] gpr_rdata,
  output logic gpr_valid,
  output logic gpr_error,
  // Segment selector loads
  input wire logic seg_load,
  input wire logic [2:0] seg_index,
  input wire logic seg_implicit,
  input wire logic [15:0] seg_sel_in,
  input wire logic [63:0] seg_base_in,
  input wire logic seg_sel_ok,
  output logic seg_fault,
  output logic [15:0] code_selector,
  output logic [15:0] stack_selector,
  output logic [15:0] primary_data_selector,
  output logic [15:0] extra_data_selector,
  output logic [15:0] third_data_selector,
  output logic [15:0] fourth_data_selector,
  // Address support
  input wire logic [63:0] next_instruction_offset,
  input wire logic [2:0] addr_seg,
  output logic [63:0] fetch_address,
  output logic [15:0] fetch_selector,
  output logic [63:0] addr_seg_base,
  output logic addr_limit_check,
  // Flag transfers
  input wire logic flag_group_write,
  input wire logic flag_low_byte_only,
  input wire logic [31:0] flag_group_data,
  input wire logic task_switch,
  input wire logic [31:0] task_flags_in,
  input wire logic handler_call,
  output logic [63:0] wide_processor_flags,
  output logic [31:0] flag_save_data,
  output logic task_flags_save,
  output logic stack_flags_push
);
  localparam int IDX_W = $clog2(NUM_GPR);

  logic [31:0] processor_flags_reg;
  logic [15:0] sel_reg [6];
  logic [63:0] base_reg [6];
  gsf_flag_state_t fl_state_reg;
  logic [31:0] task_pending_reg;
  logic [IDX_W-1:0] phys_index;
  logic illegal_access;
  logic [63:0] old_value;
  logic [63:0] merged;
  logic mem_wr;
  logic [63:0] mem_rdata;
  logic pend_write_reg;
  logic [IDX_W-1:0] pend_index_reg;
  logic [63:0] pend_data_reg;
  logic pend_byte_reg;
  logic pend_word_reg;
  logic pend_wide_reg;
  logic pend_high_reg;
  logic pend_read_reg;
  logic [63:0] fetch_base;

  // Byte codes 4..7 alias to high bytes of 0..3 without the prefix
  function automatic logic is_high_byte(input logic [3:0] code, input logic prefix, input logic byte_op);
    is_high_byte = byte_op && !prefix && code[3:2] == 2'h1;
  endfunction : is_high_byte

  // Flat segments report zero base in 64-bit mode
  function automatic logic seg_base_forced(input logic [2:0] idx, input gsf_mode_t mode);
    seg_base_forced = mode == GSF_MODE_LONG && idx != `GSF_SEG_THIRD && idx != `GSF_SEG_FOURTH;
  endfunction : seg_base_forced

  always_comb begin
    illegal_access = 1'b0;
    phys_index = gpr_code[IDX_W-1:0];
    if (is_high_byte(gpr_code, gpr_prefix, gpr_byte_op)) begin
      phys_index = IDX_W'(gpr_code - `GSF_HIGH_BYTE_ALIAS);
    end
    if ((gpr_code[3] || gpr_wide) && !gpr_prefix) begin
      illegal_access = 1'b1;
    end
    if ((gpr_code[3] || gpr_wide) && cpu_mode != GSF_MODE_LONG) begin
      illegal_access = 1'b1;
    end
  end

  // Writes are read-modify-write: capture, then merge next cycle
  always_ff @(posedge clock) begin
    if (reset || init) begin
      pend_write_reg <= 1'b0;
      pend_read_reg <= 1'b0;
      pend_index_reg <= '0;
      pend_data_reg <= '0;
      pend_byte_reg <= 1'b0;
      pend_word_reg <= 1'b0;
      pend_wide_reg <= 1'b0;
      pend_high_reg <= 1'b0;
    end else begin
      pend_write_reg <= gpr_req && gpr_write && !illegal_access;
      pend_read_reg <= gpr_req && !illegal_access;
      pend_index_reg <= phys_index;
      pend_data_reg <= gpr_wdata;
      pend_byte_reg <= gpr_byte_op;
      pend_word_reg <= gpr_word_op && !gpr_byte_op;
      pend_wide_reg <= gpr_wide;
      pend_high_reg <= is_high_byte(gpr_code, gpr_prefix, gpr_byte_op);
    end
  end

  assign old_value = mem_rdata;

  always_comb begin
    merged = old_value;
    if (pend_byte_reg && pend_high_reg) begin
      merged[15:8] = pend_data_reg[7:0];
    end else if (pend_byte_reg) begin
      merged[7:0] = pend_data_reg[7:0];
    end else if (pend_word_reg) begin
      merged[15:0] = pend_data_reg[15:0];
    end else if (pend_wide_reg) begin
      merged = pend_data_reg;
    end else begin
      merged = {32'h0000_0000, pend_data_reg[31:0]};
    end
  end

  assign mem_wr = pend_write_reg;

  // Storage is never cleared on a mode change, so upper eight survive
  // compatibility trips; legacy trips leave them undefined anyway
  gsf_regmem #(
    .DEPTH(NUM_GPR),
    .WIDTH(64)
  ) u_regmem (
    .clock(clock),
    .wr_index(pend_index_reg),
    .wr_enable(mem_wr),
    .wr_data(merged),
    .rd_index(pend_write_reg ? pend_index_reg : phys_index),
    .rd_data(mem_rdata)
  );

  // Read result is formatted for the operand width of the request
  always_ff @(posedge clock) begin
    if (reset || init) begin
      gpr_rdata <= '0;
      gpr_valid <= 1'b0;
      gpr_error <= 1'b0;
    end else begin
      gpr_valid <= pend_read_reg && !pend_write_reg;
      gpr_error <= gpr_req && illegal_access;
      if (pend_read_reg && !pend_write_reg) begin
        if (pend_byte_reg && pend_high_reg) begin
          gpr_rdata <= {56'h0, mem_rdata[15:8]};
        end else if (pend_byte_reg) begin
          gpr_rdata <= {56'h0, mem_rdata[7:0]};
        end else if (pend_word_reg) begin
          gpr_rdata <= {48'h0, mem_rdata[15:0]};
        end else if (pend_wide_reg) begin
          gpr_rdata <= mem_rdata;
        end else begin
          gpr_rdata <= {32'h0, mem_rdata[31:0]};
        end
      end
    end
  end

  // Segment selectors and hidden bases
  always_ff @(posedge clock) begin
    if (reset || init) begin
      for (int i = 0; i < 6; i++) begin
        sel_reg[i] <= 16'h0000;
        base_reg[i] <= 64'h0;
      end
      seg_fault <= 1'b0;
    end else begin
      seg_fault <= 1'b0;
      if (seg_load) begin
        if (seg_index == `GSF_SEG_CODE && !seg_implicit) begin
          seg_fault <= 1'b1;
        end else if (!seg_sel_ok) begin
          seg_fault <= 1'b1;
        end else if (seg_index < 3'h6) begin
          sel_reg[seg_index] <= seg_sel_in;
          base_reg[seg_index] <= seg_base_in;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset || init) begin
      code_selector <= 16'h0;
      stack_selector <= 16'h0;
      primary_data_selector <= 16'h0;
      extra_data_selector <= 16'h0;
      third_data_selector <= 16'h0;
      fourth_data_selector <= 16'h0;
    end else begin
      code_selector <= sel_reg[`GSF_SEG_CODE];
      stack_selector <= sel_reg[`GSF_SEG_STACK];
      primary_data_selector <= sel_reg[`GSF_SEG_DATA];
      extra_data_selector <= sel_reg[`GSF_SEG_EXTRA];
      third_data_selector <= sel_reg[`GSF_SEG_THIRD];
      fourth_data_selector <= sel_reg[`GSF_SEG_FOURTH];
    end
  end

  assign fetch_base = seg_base_forced(`GSF_SEG_CODE, cpu_mode) ? 64'h0 : base_reg[`GSF_SEG_CODE];

  always_ff @(posedge clock) begin
    if (reset || init) begin
      fetch_address <= 64'h0;
      fetch_selector <= 16'h0;
      addr_seg_base <= 64'h0;
      addr_limit_check <= 1'b0;
    end else begin
      fetch_address <= fetch_base + next_instruction_offset;
      fetch_selector <= sel_reg[`GSF_SEG_CODE];
      if (addr_seg > 3'h5 || seg_base_forced(addr_seg, cpu_mode)) begin
        addr_seg_base <= 64'h0;
      end else begin
        addr_seg_base <= base_reg[addr_seg];
      end
      addr_limit_check <= cpu_mode != GSF_MODE_LONG;
    end
  end

  // Flags: sequenced save/load for task switch, push on handler call
  always_ff @(posedge clock) begin
    if (reset || init) begin
      processor_flags_reg <= `GSF_FLAGS_RESET;
      fl_state_reg <= GSF_FL_IDLE;
      task_pending_reg <= 32'h0;
      flag_save_data <= 32'h0;
      task_flags_save <= 1'b0;
      stack_flags_push <= 1'b0;
    end else begin
      task_flags_save <= 1'b0;
      stack_flags_push <= 1'b0;
      case (fl_state_reg)
        GSF_FL_IDLE: begin
          if (task_switch) begin
            flag_save_data <= processor_flags_reg;
            task_flags_save <= 1'b1;
            task_pending_reg <= task_flags_in;
            fl_state_reg <= GSF_FL_LOAD;
          end else if (handler_call) begin
            flag_save_data <= processor_flags_reg;
            stack_flags_push <= 1'b1;
            fl_state_reg <= GSF_FL_PUSH;
          end else if (flag_group_write) begin
            // Only group moves exist; no whole-register port
            if (flag_low_byte_only) begin
              processor_flags_reg <= (processor_flags_reg & ~`GSF_LOW_GROUP_MASK)
                | (flag_group_data & `GSF_LOW_GROUP_MASK) | `GSF_FLAGS_RESET;
            end else begin
              processor_flags_reg <= (flag_group_data & `GSF_FLAGS_WRITE_MASK) | `GSF_FLAGS_RESET;
            end
          end
        end
        GSF_FL_LOAD: begin
          processor_flags_reg <= (task_pending_reg & `GSF_FLAGS_WRITE_MASK) | `GSF_FLAGS_RESET;
          fl_state_reg <= GSF_FL_IDLE;
        end
        GSF_FL_PUSH: begin
          fl_state_reg <= GSF_FL_IDLE;
        end
        GSF_FL_SAVE: begin
          fl_state_reg <= GSF_FL_IDLE;
        end
        default: begin
          fl_state_reg <= GSF_FL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset || init) begin
      wide_processor_flags <= {32'h0, `GSF_FLAGS_RESET};
    end else begin
      wide_processor_flags <= {32'h0, processor_flags_reg};
    end
  end

  a_flags_reset: assert property (@(posedge clock) (reset || init) |=> ##1 wide_processor_flags == 64'h2)
    else $error("flags not at reset value");
  a_reserved_fixed: assert property (@(posedge clock) disable iff (reset)
    (wide_processor_flags[31:0] & `GSF_FLAGS_FIXED_MASK) == `GSF_FLAGS_RESET)
    else $error("reserved flag bits changed");
  a_upper_flags: assert property (@(posedge clock) disable iff (reset) wide_processor_flags[63:32] == 32'h0)
    else $error("upper flag half not zero");
  a_code_explicit: assert property (@(posedge clock) disable iff (reset || init)
    seg_load && !seg_implicit && seg_index == 3'h0 |=> seg_fault && $stable(sel_reg[0]))
    else $error("explicit code selector load accepted");
  a_stack_load: assert property (@(posedge clock) disable iff (reset || init)
    seg_load && seg_sel_ok && seg_index == 3'h1 |=> ##1 stack_selector == $past(seg_sel_in, 2))
    else $error("stack selector load lost");
  a_limit_off: assert property (@(posedge clock) disable iff (reset || init)
    cpu_mode == GSF_MODE_LONG |=> !addr_limit_check)
    else $error("limit check in 64-bit mode");
  a_flat_base: assert property (@(posedge clock) disable iff (reset || init)
    cpu_mode == GSF_MODE_LONG && addr_seg < 3'h4 |=> addr_seg_base == 64'h0)
    else $error("flat segment base not zero");
  a_task_order: assert property (@(posedge clock) disable iff (reset || init)
    task_flags_save |=> (processor_flags_reg & `GSF_FLAGS_WRITE_MASK)
      == ($past(task_pending_reg) & `GSF_FLAGS_WRITE_MASK))
    else $error("task flags not loaded after save");
  a_bad_prefix: assert property (@(posedge clock) disable iff (reset || init)
    gpr_req && gpr_code[3] && !gpr_prefix |=> gpr_error ##1 !gpr_valid)
    else $error("upper register without prefix accepted");
  a_dword_zext: assert property (@(posedge clock) disable iff (reset || init)
    pend_write_reg && !pend_byte_reg && !pend_word_reg && !pend_wide_reg |-> merged[63:32] == 32'h0)
    else $error("dword write not zero-extended");
  a_byte_keep: assert property (@(posedge clock) disable iff (reset || init)
    pend_write_reg && pend_byte_reg && !pend_high_reg |-> merged[63:8] == old_value[63:8])
    else $error("byte write disturbed upper bits");
endmodule : gsf_state
`default_nettype wire

// ### dv/gsf_exec_model.sv
// Execute-stage model that drives the general register port
`timescale 1ns/1ps
`default_nettype none
module gsf_exec_model (
  input wire logic clock,
  output logic gpr_req,
  output logic gpr_write,
  output logic [3:0] gpr_code,
  output logic gpr_prefix,
  output logic gpr_wide,
  output logic gpr_byte_op,
  output logic gpr_word_op,
  output logic [63:0] gpr_wdata,
  input wire logic [63:0] gpr_rdata,
  input wire logic gpr_valid,
  input wire logic gpr_error
);
  initial begin
    gpr_req = 1'b0;
    gpr_write = 1'b0;
    gpr_code = 4'h0;
    gpr_prefix = 1'b0;
    gpr_wide = 1'b0;
    gpr_byte_op = 1'b0;
    gpr_word_op = 1'b0;
    gpr_wdata = 64'h0;
  end
  // Size: 0 qword, 1 dword, 2 word, 3 byte; entered just after a falling edge
  task automatic issue(input logic wr, input logic [3:0] code, input logic pfx, input logic [1:0] sz,
      input logic [63:0] data, output logic err);
    gpr_req = 1'b1;
    gpr_write = wr;
    gpr_code = code;
    gpr_prefix = pfx;
    gpr_wide = (sz == 2'h0);
    gpr_word_op = (sz == 2'h2);
    gpr_byte_op = (sz == 2'h3);
    gpr_wdata = data;
    @(negedge clock);
    // The refusal flag stands only in the cycle after the request edge
    err = gpr_error;
    gpr_req = 1'b0;
    gpr_write = 1'b0;
    // Stale data is inverted so a late sample cannot match by luck
    gpr_wdata = ~data;
    @(negedge clock);
  endtask : issue
  task automatic write_reg(input logic [3:0] code, input logic pfx, input logic [1:0] sz,
      input logic [63:0] data, output logic err);
    issue(1'b1, code, pfx, sz, data, err);
  endtask : write_reg
  task automatic read_reg(input logic [3:0] code, input logic pfx, input logic [1:0] sz,
      output logic [63:0] data, output logic vld, output logic err);
    // Valid stands for one cycle, right after the second edge; read data holds until the next read
    issue(1'b0, code, pfx, sz, 64'h0, err);
    vld = gpr_valid;
    data = gpr_rdata;
  endtask : read_reg
endmodule : gsf_exec_model
`default_nettype wire

// ### dv/gpr_segment_flag_state_tb.sv
// Self-checking bench for the register, segment and flag state block
`timescale 1ns/1ps
`default_nettype none
`include "gsf_cfg.svh"
`define GSF_CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, (got), (exp)); end end
module gpr_segment_flag_state_tb
  import gsf_pkg::*;
;
  logic clock = 1'b0;
  logic reset, init;
  gsf_mode_t cpu_mode;
  logic gpr_req, gpr_write, gpr_prefix, gpr_wide, gpr_byte_op, gpr_word_op, gpr_valid, gpr_error;
  logic [3:0] gpr_code;
  logic [63:0] gpr_wdata, gpr_rdata, seg_base_in, next_instruction_offset, fetch_address, addr_seg_base;
  logic seg_load, seg_implicit, seg_sel_ok, seg_fault, addr_limit_check;
  logic [2:0] seg_index, addr_seg;
  logic [15:0] seg_sel_in, code_selector, stack_selector, primary_data_selector, extra_data_selector;
  logic [15:0] third_data_selector, fourth_data_selector, fetch_selector;
  logic flag_group_write, flag_low_byte_only, task_switch, handler_call, task_flags_save, stack_flags_push;
  logic [31:0] flag_group_data, task_flags_in, flag_save_data;
  logic [63:0] wide_processor_flags, d;
  logic v, e, saw_save, saw_push;
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  always #2.5 clock = ~clock;

  gsf_exec_model u_gsf_exec_model (.clock, .gpr_req, .gpr_write, .gpr_code, .gpr_prefix, .gpr_wide,
    .gpr_byte_op, .gpr_word_op, .gpr_wdata, .gpr_rdata, .gpr_valid, .gpr_error);

  gsf_state u_gsf_state (.clock, .reset, .init, .cpu_mode, .gpr_req, .gpr_write, .gpr_code, .gpr_prefix,
    .gpr_wide, .gpr_byte_op, .gpr_word_op, .gpr_wdata, .gpr_rdata, .gpr_valid, .gpr_error, .seg_load,
    .seg_index, .seg_implicit, .seg_sel_in, .seg_base_in, .seg_sel_ok, .seg_fault, .code_selector,
    .stack_selector, .primary_data_selector, .extra_data_selector, .third_data_selector,
    .fourth_data_selector, .next_instruction_offset, .addr_seg, .fetch_address, .fetch_selector,
    .addr_seg_base, .addr_limit_check, .flag_group_write, .flag_low_byte_only, .flag_group_data, .task_switch,
    .task_flags_in, .handler_call, .wide_processor_flags, .flag_save_data, .task_flags_save,
    .stack_flags_push);

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // Whole run is about 113 cycles; the ceiling leaves wide margin
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic wr_chk(input logic [3:0] code, input logic pfx, input logic [1:0] sz, input logic [63:0] data,
      input logic exp_err);
    u_gsf_exec_model.write_reg(code, pfx, sz, data, e);
    `GSF_CHECK(e, exp_err)
  endtask : wr_chk

  task automatic rd_chk(input logic [3:0] code, input logic pfx, input logic [1:0] sz, input logic [63:0] exp);
    u_gsf_exec_model.read_reg(code, pfx, sz, d, v, e);
    `GSF_CHECK(v, 1'b1)
    `GSF_CHECK(d, exp)
  endtask : rd_chk

  task automatic seg_op(input logic [2:0] idx, input logic impl, input logic ok, input logic [15:0] sel,
      input logic [63:0] base, input logic exp_fault);
    seg_load = 1'b1;
    seg_index = idx;
    seg_implicit = impl;
    seg_sel_ok = ok;
    seg_sel_in = sel;
    seg_base_in = base;
    @(negedge clock);
    // The fault pulse stands only in the cycle after the load edge
    `GSF_CHECK(seg_fault, exp_fault)
    seg_load = 1'b0;
    repeat (3) @(negedge clock);
  endtask : seg_op

  // Kind: 0 group write, 1 low-byte group, 2 task switch, 3 handler call
  task automatic flag_op(input logic [1:0] kind, input logic [31:0] data);
    flag_group_write = (kind < 2'h2);
    flag_low_byte_only = (kind == 2'h1);
    flag_group_data = data;
    task_flags_in = data;
    task_switch = (kind == 2'h2);
    handler_call = (kind == 2'h3);
    @(negedge clock);
    // Save and push strobes stand for one cycle only
    saw_save = task_flags_save;
    saw_push = stack_flags_push;
    flag_group_write = 1'b0;
    task_switch = 1'b0;
    handler_call = 1'b0;
    @(negedge clock);
  endtask : flag_op

  initial begin
    reset = 1'b1;
    init = 1'b0;
    cpu_mode = GSF_MODE_LONG;
    seg_load = 1'b0;
    seg_index = 3'h0;
    seg_implicit = 1'b0;
    seg_sel_in = 16'h0;
    seg_base_in = 64'h0;
    seg_sel_ok = 1'b1;
    next_instruction_offset = 64'h0000_7000_1234_5678;
    addr_seg = `GSF_SEG_CODE;
    flag_group_write = 1'b0;
    flag_low_byte_only = 1'b0;
    flag_group_data = 32'h0;
    task_switch = 1'b0;
    task_flags_in = 32'h0;
    handler_call = 1'b0;
    repeat (10) @(negedge clock);
    reset = 1'b0;
    repeat (2) @(negedge clock);
    `GSF_CHECK(wide_processor_flags, 64'h0000_0000_0000_0002)
    wr_chk(4'h9, 1'b1, 2'h0, 64'h1122_3344_5566_7788, 1'b0);
    rd_chk(4'h9, 1'b1, 2'h0, 64'h1122_3344_5566_7788);
    wr_chk(4'h9, 1'b1, 2'h1, 64'hffff_ffff_a5a5_a5a5, 1'b0);
    rd_chk(4'h9, 1'b1, 2'h0, 64'h0000_0000_a5a5_a5a5);
    wr_chk(4'h9, 1'b1, 2'h2, 64'hffff_ffff_ffff_beef, 1'b0);
    wr_chk(4'h9, 1'b1, 2'h3, 64'hffff_ffff_ffff_ff3c, 1'b0);
    rd_chk(4'h9, 1'b1, 2'h0, 64'h0000_0000_a5a5_be3c);
    rd_chk(4'h9, 1'b1, 2'h3, 64'h0000_0000_0000_003c);
    rd_chk(4'h9, 1'b1, 2'h2, 64'h0000_0000_0000_be3c);
    wr_chk(4'h9, 1'b0, 2'h1, 64'h0, 1'b1);
    wr_chk(4'h1, 1'b0, 2'h0, 64'h0, 1'b1);
    rd_chk(4'h9, 1'b1, 2'h0, 64'h0000_0000_a5a5_be3c);
    wr_chk(4'h0, 1'b0, 2'h1, 64'h0, 1'b0);
    wr_chk(4'h4, 1'b1, 2'h0, 64'h0, 1'b0);
    wr_chk(4'h4, 1'b0, 2'h3, 64'h0000_0000_0000_005a, 1'b0);
    wr_chk(4'h4, 1'b1, 2'h3, 64'h0000_0000_0000_0069, 1'b0);
    rd_chk(4'h0, 1'b0, 2'h1, 64'h0000_0000_0000_5a00);
    rd_chk(4'h4, 1'b1, 2'h0, 64'h0000_0000_0000_0069);
    cpu_mode = GSF_MODE_COMPAT;
    repeat (2) @(negedge clock);
    wr_chk(4'h9, 1'b1, 2'h0, 64'h0, 1'b1);
    `GSF_CHECK(addr_limit_check, 1'b1)
    cpu_mode = GSF_MODE_LONG;
    repeat (2) @(negedge clock);
    rd_chk(4'h9, 1'b1, 2'h0, 64'h0000_0000_a5a5_be3c);
    seg_op(`GSF_SEG_CODE, 1'b0, 1'b1, 16'h0010, 64'h0, 1'b1);
    `GSF_CHECK(code_selector, 16'h0000)
    seg_op(`GSF_SEG_CODE, 1'b1, 1'b1, 16'h0018, 64'h0, 1'b0);
    `GSF_CHECK(code_selector, 16'h0018)
    `GSF_CHECK(fetch_selector, 16'h0018)
    `GSF_CHECK(fetch_address, 64'h0000_7000_1234_5678)
    seg_op(`GSF_SEG_STACK, 1'b0, 1'b1, 16'h0023, 64'h0, 1'b0);
    `GSF_CHECK(stack_selector, 16'h0023)
    seg_op(`GSF_SEG_DATA, 1'b0, 1'b0, 16'h002b, 64'h0, 1'b1);
    `GSF_CHECK(primary_data_selector, 16'h0000)
    seg_op(`GSF_SEG_EXTRA, 1'b0, 1'b1, 16'h003b, 64'h0000_0000_dead_0000, 1'b0);
    `GSF_CHECK(extra_data_selector, 16'h003b)
    seg_op(`GSF_SEG_FOURTH, 1'b0, 1'b1, 16'h0043, 64'h0000_2000_0000_0000, 1'b0);
    `GSF_CHECK(fourth_data_selector, 16'h0043)
    seg_op(`GSF_SEG_THIRD, 1'b0, 1'b1, 16'h0033, 64'h0000_1000_0000_0000, 1'b0);
    `GSF_CHECK(third_data_selector, 16'h0033)
    addr_seg = `GSF_SEG_THIRD;
    repeat (3) @(negedge clock);
    `GSF_CHECK(addr_seg_base, 64'h0000_1000_0000_0000)
    `GSF_CHECK(addr_limit_check, 1'b0)
    addr_seg = `GSF_SEG_EXTRA;
    repeat (3) @(negedge clock);
    `GSF_CHECK(addr_seg_base, 64'h0)
    flag_op(2'h0, 32'hffff_ffff);
    repeat (3) @(negedge clock);
    `GSF_CHECK(wide_processor_flags, 64'h0000_0000_003f_7fd7)
    flag_op(2'h1, 32'h0000_0000);
    repeat (3) @(negedge clock);
    `GSF_CHECK(wide_processor_flags, 64'h0000_0000_003f_7f02)
    flag_op(2'h2, 32'hffc0_0001);
    `GSF_CHECK(saw_save, 1'b1)
    `GSF_CHECK(saw_push, 1'b0)
    `GSF_CHECK(flag_save_data, 32'h003f_7f02)
    repeat (3) @(negedge clock);
    `GSF_CHECK(wide_processor_flags, 64'h0000_0000_0000_0003)
    flag_op(2'h3, 32'h0);
    `GSF_CHECK(saw_push, 1'b1)
    `GSF_CHECK(saw_save, 1'b0)
    `GSF_CHECK(flag_save_data, 32'h0000_0003)
    repeat (3) @(negedge clock);
    init = 1'b1;
    @(negedge clock);
    init = 1'b0;
    repeat (2) @(negedge clock);
    `GSF_CHECK(wide_processor_flags, 64'h0000_0000_0000_0002)
    report_and_stop();
  end
endmodule : gpr_segment_flag_state_tb
`default_nettype wire
